// >>> eep_pkg.sv
/*
 * Shared constants and types of the two-wire serial EEPROM target port.
 * Assumes a 250 MHz system clock and a separate free-running link clock
 * that oversamples the bus pins.
 */
package eep_pkg;

  localparam logic [3:0] CTRL_CODE = 4'ha;
  localparam int PAGE_W = 6;
  localparam int PAGE_BYTES = 64;
  localparam int ADDR_W_SMALL = 14;
  localparam int ADDR_W_LARGE = 15;
  localparam int FIFO_DEPTH = 4;

  localparam int CLK_PERIOD_NS = 4;
  localparam int TWR_MS = 5;
  // longest time, so the division rounds down
  localparam int TWR_CYC = (TWR_MS * 1000000) / CLK_PERIOD_NS;

  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_RX = 5'h02,
    ST_ACK = 5'h04,
    ST_TX = 5'h08,
    ST_RACK = 5'h10
  } eep_state_t;

  typedef struct packed {
    logic [PAGE_W-1:0] off;
    logic [7:0] data;
  } eep_wbyte_t;

endpackage

// >>> eep_sync.sv
/*
 * Two flip-flop level synchroniser.
 * Assumes its input is a level from another clock domain or a pin.
 */
`timescale 1ns/1ns
module eep_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_q;

  if (W < 1) begin : g_bad_w
    $error("eep_sync: width must be at least 1");
  end

  always_ff @(posedge clk) begin
    meta_q <= d;
    q <= meta_q;
  end

endmodule // eep_sync

// >>> eep_fifo.sv
/*
 * Single-clock FIFO with valid and ready on both sides.
 * Assumes both sides run on clk; depth is a power of two.
 */
`timescale 1ns/1ns
module eep_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW-1:0] wr_q;
  logic [PW-1:0] rd_q;
  logic [PW:0] cnt_q;
  logic push;
  logic pop;

  if (DEPTH < 2 || (1 << PW) != DEPTH) begin : g_bad_depth
    $error("eep_fifo: depth must be a power of two, at least 2");
  end
  if (WIDTH < 1) begin : g_bad_width
    $error("eep_fifo: width must be at least 1");
  end

  assign in_ready = (cnt_q != (PW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data = mem_q[rd_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) wr_q <= wr_q + 1'b1;
      if (pop) rd_q <= rd_q + 1'b1;
      if (push && !pop) cnt_q <= cnt_q + 1'b1;
      else if (pop && !push) cnt_q <= cnt_q - 1'b1;
    end
  end

endmodule // eep_fifo

// >>> eep_port.sv
/*
 * Two-wire bus target port of a byte-wide serial EEPROM: bit engine,
 * array, page latch and self-timed programming cycle.
 * Assumes link_clk oversamples the bus pins well above the serial clock
 * rate, and that the pad supplies the open-drain wire and pull-downs.
 */
`timescale 1ns/1ns
module eep_port #(
  parameter int ADDR_W = eep_pkg::ADDR_W_LARGE,
  parameter int WR_CYCLES = eep_pkg::TWR_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic link_clk,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o_q,
  output logic sda_oe_q,
  input wire logic addr_strap_bit0,
  input wire logic addr_strap_bit1,
  input wire logic addr_strap_bit2,
  input wire logic wp_i,
  output logic write_busy_q
);

  localparam int MEM_BYTES = 1 << ADDR_W;
  localparam int PW = eep_pkg::PAGE_W;

  if (ADDR_W != eep_pkg::ADDR_W_SMALL && ADDR_W != eep_pkg::ADDR_W_LARGE) begin : g_bad_addr_w
    $error("eep_port: ADDR_W must be 14 or 15");
  end
  if (WR_CYCLES < 2) begin : g_bad_wr_cycles
    $error("eep_port: WR_CYCLES must be at least 2");
  end

  // ---------------- link domain ----------------
  logic lrst;
  logic [5:0] pins_s;
  logic scl_s, sda_s, wp_s;
  logic [2:0] strap_s;
  logic scl_p_q, sda_p_q;
  logic start_ev, stop_ev, scl_rise, scl_fall;

  eep_sync #(.W(1)) u_rst_sync (.clk(link_clk), .d(rst), .q(lrst));
  // undriven straps and write-protect read low through the pad pull-downs
  eep_sync #(.W(6)) u_pin_sync (
    .clk(link_clk),
    .d({scl_i, sda_i, wp_i, addr_strap_bit2, addr_strap_bit1, addr_strap_bit0}),
    .q(pins_s)
  );
  assign {scl_s, sda_s, wp_s, strap_s} = pins_s;

  always_ff @(posedge link_clk) begin
    if (lrst) begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
    end
  end

  assign start_ev = scl_s && scl_p_q && sda_p_q && !sda_s;
  assign stop_ev = scl_s && scl_p_q && !sda_p_q && sda_s;
  assign scl_rise = scl_s && !scl_p_q;
  assign scl_fall = !scl_s && scl_p_q;

  eep_pkg::eep_state_t state_q;
  logic [7:0] shreg_q;
  logic [3:0] bitcnt_q;
  logic [1:0] byte_n_q;
  logic rw_q, more_q, busy_q;
  logic [ADDR_W-1:0] addr_q;
  logic [7:0] mem_q [MEM_BYTES];
  logic [7:0] mem_rd;
  logic byte_done, ack_ok, tx_load, quiet;
  logic fifo_in_ready, fifo_out_valid, fifo_out_ready;
  eep_pkg::eep_wbyte_t fifo_in, fifo_out;

  assign quiet = !start_ev && !stop_ev;
  assign mem_rd = mem_q[addr_q];
  assign byte_done = quiet && state_q == eep_pkg::ST_RX && scl_fall && bitcnt_q == eep_pkg::BITS_PER_BYTE;
  assign tx_load = quiet && scl_fall
    && ((state_q == eep_pkg::ST_ACK && rw_q) || (state_q == eep_pkg::ST_RACK && more_q));

  always_comb begin
    unique case (byte_n_q)
      2'h0: ack_ok = shreg_q[7:4] == eep_pkg::CTRL_CODE && shreg_q[3:1] == strap_s && !busy_q;
      2'h3: ack_ok = fifo_in_ready;
      default: ack_ok = 1'b1;
    endcase
  end

  // bit engine
  always_ff @(posedge link_clk) begin
    if (lrst) begin
      state_q <= eep_pkg::ST_IDLE;
      shreg_q <= 8'h00;
      bitcnt_q <= 4'h0;
      byte_n_q <= 2'h0;
      rw_q <= 1'b0;
      more_q <= 1'b0;
      sda_oe_q <= 1'b0;
    end else if (start_ev) begin
      state_q <= eep_pkg::ST_RX;
      bitcnt_q <= 4'h0;
      byte_n_q <= 2'h0;
      sda_oe_q <= 1'b0;
    end else if (stop_ev) begin
      state_q <= eep_pkg::ST_IDLE;
      sda_oe_q <= 1'b0;
    end else begin
      unique case (state_q)
        eep_pkg::ST_IDLE: begin
          sda_oe_q <= 1'b0;
        end
        eep_pkg::ST_RX: begin
          if (scl_rise && bitcnt_q != eep_pkg::BITS_PER_BYTE) begin
            shreg_q <= {shreg_q[6:0], sda_s};
            bitcnt_q <= bitcnt_q + 4'h1;
          end else if (byte_done) begin
            bitcnt_q <= 4'h0;
            sda_oe_q <= ack_ok;
            state_q <= ack_ok ? eep_pkg::ST_ACK : eep_pkg::ST_IDLE;
            if (ack_ok && byte_n_q != 2'h3) byte_n_q <= byte_n_q + 2'h1;
            if (ack_ok && byte_n_q == 2'h0) rw_q <= shreg_q[0];
          end
        end
        eep_pkg::ST_ACK: begin
          if (tx_load) begin
            shreg_q <= mem_rd;
            sda_oe_q <= !mem_rd[7];
            bitcnt_q <= 4'h1;
            state_q <= eep_pkg::ST_TX;
          end else if (scl_fall) begin
            sda_oe_q <= 1'b0;
            state_q <= eep_pkg::ST_RX;
          end
        end
        eep_pkg::ST_TX: begin
          if (scl_fall && bitcnt_q == eep_pkg::BITS_PER_BYTE) begin
            sda_oe_q <= 1'b0;
            more_q <= 1'b0;
            state_q <= eep_pkg::ST_RACK;
          end else if (scl_fall) begin
            sda_oe_q <= !shreg_q[6];
            shreg_q <= {shreg_q[6:0], 1'b0};
            bitcnt_q <= bitcnt_q + 4'h1;
          end
        end
        eep_pkg::ST_RACK: begin
          if (scl_rise) begin
            more_q <= !sda_s;
          end else if (tx_load) begin
            shreg_q <= mem_rd;
            sda_oe_q <= !mem_rd[7];
            bitcnt_q <= 4'h1;
            state_q <= eep_pkg::ST_TX;
          end else if (scl_fall) begin
            state_q <= eep_pkg::ST_IDLE;
          end
        end
        default: begin
          state_q <= eep_pkg::ST_IDLE;
          sda_oe_q <= 1'b0;
        end
      endcase
    end
  end

  // the port never drives the wire high
  always_ff @(posedge link_clk) begin
    sda_o_q <= 1'b0;
  end

  // byte address
  always_ff @(posedge link_clk) begin
    if (lrst) begin
      addr_q <= '0;
    end else if (byte_done && ack_ok && byte_n_q == 2'h1) begin
      addr_q[ADDR_W-1:8] <= shreg_q[ADDR_W-9:0];
    end else if (byte_done && ack_ok && byte_n_q == 2'h2) begin
      addr_q[7:0] <= shreg_q;
    end else if (byte_done && ack_ok && byte_n_q == 2'h3) begin
      addr_q[PW-1:0] <= addr_q[PW-1:0] + 1'b1;
    end else if (tx_load) begin
      addr_q <= addr_q + 1'b1;
    end
  end

  assign fifo_in = '{off: addr_q[PW-1:0], data: shreg_q};

  eep_fifo #(.WIDTH($bits(eep_pkg::eep_wbyte_t)), .DEPTH(eep_pkg::FIFO_DEPTH)) u_fifo (
    .clk(link_clk),
    .rst(lrst),
    .in_valid(byte_done && byte_n_q == 2'h3),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out)
  );

  // page latch, programming request and commit
  logic [7:0] page_q [eep_pkg::PAGE_BYTES];
  logic [eep_pkg::PAGE_BYTES-1:0] mask_q;
  logic wr_data_q, pend_q, wp_hold_q, req_sent_q, req_tog_q, done_seen_q;
  logic done_s, done_ev;

  assign fifo_out_ready = !req_sent_q;
  assign done_ev = done_s != done_seen_q;

  always_ff @(posedge link_clk) begin
    if (fifo_out_valid && fifo_out_ready) begin
      page_q[fifo_out.off] <= fifo_out.data;
    end
  end

  always_ff @(posedge link_clk) begin
    if (lrst) begin
      mask_q <= '0;
    end else if (done_ev || (pend_q && wp_hold_q && !fifo_out_valid)) begin
      mask_q <= '0;
    end else if (fifo_out_valid && fifo_out_ready) begin
      mask_q[fifo_out.off] <= 1'b1;
    end
  end

  always_ff @(posedge link_clk) begin
    if (done_ev) begin
      for (int i = 0; i < eep_pkg::PAGE_BYTES; i++) begin
        if (mask_q[i]) mem_q[{addr_q[ADDR_W-1:PW], PW'(i)}] <= page_q[i];
      end
    end
  end

  always_ff @(posedge link_clk) begin
    if (lrst) begin
      wr_data_q <= 1'b0;
      pend_q <= 1'b0;
      wp_hold_q <= 1'b0;
      req_sent_q <= 1'b0;
      req_tog_q <= 1'b0;
      done_seen_q <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      if (byte_done && byte_n_q == 2'h3 && fifo_in_ready) wr_data_q <= 1'b1;
      else if (stop_ev) wr_data_q <= 1'b0;
      if (stop_ev && wr_data_q) begin
        pend_q <= 1'b1;
        wp_hold_q <= wp_s;
        busy_q <= 1'b1;
      end else if (pend_q && !fifo_out_valid) begin
        pend_q <= 1'b0;
        if (wp_hold_q) begin
          busy_q <= 1'b0;
        end else begin
          req_tog_q <= !req_tog_q;
          req_sent_q <= 1'b1;
        end
      end else if (done_ev) begin
        done_seen_q <= done_s;
        req_sent_q <= 1'b0;
        busy_q <= 1'b0;
      end
    end
  end

  // ---------------- system domain: programming timer ----------------
  logic req_s, req_seen_q, done_tog_q;
  logic [31:0] wr_cnt_q;

  eep_sync #(.W(1)) u_req_sync (.clk(clk), .d(req_tog_q), .q(req_s));
  eep_sync #(.W(1)) u_done_sync (.clk(link_clk), .d(done_tog_q), .q(done_s));

  always_ff @(posedge clk) begin
    if (rst) begin
      req_seen_q <= 1'b0;
      done_tog_q <= 1'b0;
      write_busy_q <= 1'b0;
      wr_cnt_q <= 32'h0000_0000;
    end else if (!write_busy_q && req_s != req_seen_q) begin
      req_seen_q <= req_s;
      write_busy_q <= 1'b1;
      wr_cnt_q <= 32'h0000_0000;
    end else if (write_busy_q && wr_cnt_q == 32'(WR_CYCLES - 1)) begin
      write_busy_q <= 1'b0;
      done_tog_q <= !done_tog_q;
    end else if (write_busy_q) begin
      wr_cnt_q <= wr_cnt_q + 32'h0000_0001;
    end
  end

  // ---------------- checks ----------------
  sequence s_dev_byte;
    byte_done && byte_n_q == 2'h0;
  endsequence
  sequence s_data_byte;
    byte_done && byte_n_q == 2'h3 && fifo_in_ready;
  endsequence

  AST_NEVER_HIGH: assert property (@(posedge link_clk) disable iff (lrst)
    sda_o_q == 1'b0 && (!sda_oe_q || state_q == eep_pkg::ST_ACK || state_q == eep_pkg::ST_TX))
    else $error("data line driven high or pulled outside an acknowledge or read bit");
  AST_OUT_AFTER_FALL: assert property (@(posedge link_clk) disable iff (lrst)
    ($past(state_q) == eep_pkg::ST_TX && $changed(sda_oe_q) && !$past(start_ev || stop_ev)) |-> $past(scl_fall))
    else $error("read data changed without a falling clock edge");
  AST_SAMPLE_RISE: assert property (@(posedge link_clk) disable iff (lrst)
    (state_q == eep_pkg::ST_RX && scl_rise && quiet && bitcnt_q != eep_pkg::BITS_PER_BYTE)
    |=> shreg_q[0] == $past(sda_s) && bitcnt_q == $past(bitcnt_q) + 4'h1)
    else $error("bit not taken at rising clock edge");
  AST_STRAP_MISMATCH: assert property (@(posedge link_clk) disable iff (lrst)
    (s_dev_byte ##0 (shreg_q[3:1] != strap_s)) |=> !sda_oe_q ##1 !sda_oe_q)
    else $error("acknowledged a foreign device address");
  AST_BUSY_NO_ACK: assert property (@(posedge link_clk) disable iff (lrst)
    (s_dev_byte ##0 busy_q) |=> state_q == eep_pkg::ST_IDLE && !sda_oe_q)
    else $error("acknowledged while programming");
  AST_WP_BLOCKS: assert property (@(posedge link_clk) disable iff (lrst)
    (pend_q && wp_hold_q && !fifo_out_valid) |=> $stable(req_tog_q) && !busy_q && mask_q == '0)
    else $error("protected write reached programming");
  AST_PAGE_WRAP: assert property (@(posedge link_clk) disable iff (lrst)
    s_data_byte |=> addr_q[PW-1:0] == $past(addr_q[PW-1:0]) + 1'b1
      && addr_q[ADDR_W-1:PW] == $past(addr_q[ADDR_W-1:PW]))
    else $error("page address did not advance within the page");
  AST_SEQ_ADVANCE: assert property (@(posedge link_clk) disable iff (lrst)
    tx_load |=> addr_q == $past(addr_q) + 1'b1 && state_q == eep_pkg::ST_TX)
    else $error("read address did not advance");
  AST_WRITE_ENDS: assert property (@(posedge clk) disable iff (rst)
    (write_busy_q && wr_cnt_q == 32'(WR_CYCLES - 1)) |=> !write_busy_q && $changed(done_tog_q))
    else $error("programming cycle did not end on time");
  AST_WRITE_START: assert property (@(posedge clk) disable iff (rst)
    $rose(write_busy_q) |-> wr_cnt_q == 32'h0000_0000 ##1 wr_cnt_q == 32'h0000_0001)
    else $error("programming timer did not start from zero");

endmodule // eep_port

// >>> eep_bus_ctl.sv
/*
 * Two-wire bus controller model for the EEPROM port bench.
 * Assumes the bench resolves the data wire as a pull-up pulled low by pull_q or the port's enable.
 */
`timescale 1ns/1ns
module eep_bus_ctl #(
  parameter int HALF = 10
) (
  input wire logic link_clk,
  input wire logic sda,
  output logic scl_q,
  output logic pull_q
);
  // bus rate is scaled up for simulation; only the port's oversampling limits it
  initial begin
    scl_q = 1'b1;
    pull_q = 1'b0;
  end
  task automatic ph();
    repeat (HALF) @(posedge link_clk);
  endtask
  task automatic start();
    pull_q <= 1'b0;
    ph();
    scl_q <= 1'b1;
    ph();
    pull_q <= 1'b1;
    ph();
    scl_q <= 1'b0;
    ph();
  endtask
  task automatic stop();
    pull_q <= 1'b1;
    ph();
    scl_q <= 1'b1;
    ph();
    pull_q <= 1'b0;
    ph();
  endtask
  // data set mid low phase, held across the rising edge
  task automatic bit_xfer(input logic b, output logic seen);
    pull_q <= ~b;
    ph();
    scl_q <= 1'b1;
    ph();
    seen = sda;
    scl_q <= 1'b0;
    ph();
  endtask
  task automatic send(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(d[i], s);
    end
    bit_xfer(1'b1, s);
    ack = ~s;
  endtask
  task automatic recv(input logic more, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(1'b1, s);
      d[i] = s;
    end
    bit_xfer(~more, s);
  endtask
endmodule // eep_bus_ctl

// >>> testbench.sv
/*
 * Self-checking bench of the EEPROM target port: writes, reads, protection, selection.
 * Assumes eep_port with a shortened programming time and the controller model.
 */
`timescale 1ns/1ns
module testbench;
  localparam int WR = 3000;
  // strap bit 2 models an undriven pin, read as low
  localparam logic [2:0] STRAP = 3'b011;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic link_clk = 1'b0;
  logic wp = 1'b0;
  logic scl;
  logic pull;
  logic sda_o;
  logic sda_oe;
  logic busy;
  logic busy_q = 1'b0;
  logic oe_prev = 1'b0;
  int busy_len = 0;
  int cycles = 0;
  int n_fail = 0;
  int n_compared = 0;
  wire logic sda = ~(pull | sda_oe);

  always #2 clk = ~clk;
  always begin
    #7 link_clk = 1'b1;
    #8 link_clk = 1'b0;
  end

  eep_port #(.ADDR_W(15), .WR_CYCLES(WR)) eep_port_i (
    .clk(clk), .rst(rst), .link_clk(link_clk), .scl_i(scl), .sda_i(sda), .sda_o_q(sda_o),
    .sda_oe_q(sda_oe), .addr_strap_bit0(STRAP[0]), .addr_strap_bit1(STRAP[1]),
    .addr_strap_bit2(STRAP[2]), .wp_i(wp), .write_busy_q(busy)
  );
  eep_bus_ctl #(.HALF(10)) eep_bus_ctl_i (.link_clk(link_clk), .sda(sda), .scl_q(scl), .pull_q(pull));

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_of_test();
    if (n_fail == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    busy_q <= busy;
    if (busy && !busy_q) begin
      busy_len <= 1;
    end else if (busy) begin
      busy_len <= busy_len + 1;
    end
    if (cycles == 95000) begin
      n_fail++;
      end_of_test();
    end
  end
  always @(posedge link_clk) begin
    if (!rst && scl === 1'b1 && sda_oe !== oe_prev) check("oe_scl_high", sda_oe, oe_prev);
    if (!rst && sda_oe === 1'b1) check("sda_o_level", sda_o, 1'b0);
    oe_prev <= sda_oe;
  end

  task automatic dev(input logic rd, output logic ack);
    eep_bus_ctl_i.start();
    eep_bus_ctl_i.send({eep_pkg::CTRL_CODE, STRAP, rd}, ack);
  endtask
  task automatic set_addr(input logic [14:0] a);
    logic ack;
    dev(1'b0, ack);
    check("dev_ack", ack, 1'b1);
    eep_bus_ctl_i.send({1'b0, a[14:8]}, ack);
    check("addrh_ack", ack, 1'b1);
    eep_bus_ctl_i.send(a[7:0], ack);
    check("addrl_ack", ack, 1'b1);
  endtask
  task automatic write_page(input logic [14:0] a, input logic [7:0] d0, input logic [7:0] d1, input int n);
    logic ack;
    set_addr(a);
    eep_bus_ctl_i.send(d0, ack);
    check("data_ack", ack, 1'b1);
    if (n > 1) begin
      eep_bus_ctl_i.send(d1, ack);
      check("data2_ack", ack, 1'b1);
    end
    eep_bus_ctl_i.stop();
    if (wp) begin
      repeat (300) @(posedge clk);
      check("busy_protected", busy, 1'b0);
      return;
    end
    dev(1'b0, ack);
    eep_bus_ctl_i.stop();
    check("busy_nack", ack, 1'b0);
    for (int i = 0; i < 10 && !ack; i++) begin
      dev(1'b0, ack);
      eep_bus_ctl_i.stop();
    end
    check("poll_ack", ack, 1'b1);
    check("busy_len", busy_len[15:0], WR[15:0]);
  endtask
  task automatic read_check(input logic [14:0] a, input logic [7:0] e0, input logic [7:0] e1, input int n);
    logic ack;
    logic [7:0] d;
    set_addr(a);
    dev(1'b1, ack);
    check("read_dev_ack", ack, 1'b1);
    eep_bus_ctl_i.recv(n > 1, d);
    check("read_byte0", d, e0);
    if (n > 1) begin
      eep_bus_ctl_i.recv(1'b0, d);
      check("read_byte1", d, e1);
    end
    eep_bus_ctl_i.stop();
  endtask

  task automatic sc_write_wrap();
    write_page(15'h7fff, 8'h5a, 8'h00, 1);
    write_page(15'h003f, 8'hc3, 8'h3c, 2);
  endtask
  task automatic sc_read_back();
    read_check(15'h7fff, 8'h5a, 8'h3c, 2);
    read_check(15'h003f, 8'hc3, 8'h00, 1);
  endtask
  task automatic sc_protect();
    @(posedge clk);
    wp <= 1'b1;
    write_page(15'h0000, 8'hff, 8'h00, 1);
    @(posedge clk);
    wp <= 1'b0;
    read_check(15'h0000, 8'h3c, 8'h00, 1);
  endtask
  task automatic sc_wrong_addr();
    logic ack;
    eep_bus_ctl_i.start();
    eep_bus_ctl_i.send({eep_pkg::CTRL_CODE, STRAP ^ 3'b100, 1'b0}, ack);
    eep_bus_ctl_i.stop();
    check("foreign_nack", ack, 1'b0);
  endtask

  initial begin
    repeat (10) @(posedge link_clk);
    check("oe_in_reset", sda_oe, 1'b0);
    check("busy_in_reset", busy, 1'b0);
    @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge link_clk);
    sc_write_wrap();
    sc_read_back();
    sc_protect();
    sc_wrong_addr();
    end_of_test();
  end
endmodule // testbench
